/* thread_ops_map.vh */
// opcode, timing and field constants for the loop, interrupt-enable and threaded-code unit
`ifndef THREAD_OPS_MAP_VH
`define THREAD_OPS_MAP_VH
`define OPC_LOOP_LOW      4'ha
`define OPC_IRQ_ENABLE    8'h9f
`define OPC_THREAD_ENTER  8'h1f
`define OPC_THREAD_EXIT   8'h2f
`define CYC_LOOP          5'd8
`define CYC_IRQ_ENABLE    5'd4
`define CYC_THREAD_ENTER  5'd14
`define CYC_THREAD_EXIT   5'd16
`define MODE_IRQ_EN_BIT   0
`define RST_PC            16'h0000
`define RST_IP            16'h0000
`define RST_SP            16'h0000
`define RST_MODE          8'h00
`define PTR_STEP          16'h0002
`endif

/* op_cycle_timer.v */
// cycle counter that stretches each instruction to its documented length
`timescale 1ns/10ps
module op_cycle_timer #(
    parameter W = 5
) (
    input  wire         clk_in,
    input  wire         rstn_in,
    input  wire         start_in,
    input  wire [W-1:0] cycles_in,
    output reg          done_out
);
    reg [W-1:0] cnt_q;

    always @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            cnt_q    <= {W{1'b0}};
            done_out <= 1'b0;
        end else begin
            done_out <= 1'b0;
            if (start_in) begin
                cnt_q <= cycles_in - {{(W-1){1'b0}}, 1'b1};
            end else if (cnt_q != {W{1'b0}}) begin
                cnt_q <= cnt_q - {{(W-1){1'b0}}, 1'b1};
                if (cnt_q == {{(W-1){1'b0}}, 1'b1}) begin
                    done_out <= 1'b1;
                end
            end
        end
    end
endmodule

/* thread_ops_core.v */
// execution unit for loop decrement-branch, global interrupt enable, threaded enter and exit
// Operation
// - The loop opcode rA decrements working register r by one and always takes 8 cycles.
// - If the decremented register is nonzero the signed displacement is added to the PC.
// - The displacement is a signed byte covering +127 to -128.
// - The PC it is added to is the address of the byte after the loop instruction.
// - None of the four instructions changes any condition flag.
// - Opcode 9F takes 4 cycles and sets bit 0 of the system mode register.
// - A pending interrupt held off while disabled is serviced once enable executes.
// - Opcode 1F takes 14 cycles, lowers the stack pointer by 2, stores the pointer there.
// - Enter then copies the PC into the instruction pointer.
// - Enter then loads the PC from program memory at the pointer and adds two to it.
// - Opcode 2F takes 16 cycles, reloads the pointer from the stack, raises it by 2.
// - Exit then loads the PC from program memory at the pointer and adds two to it.
`timescale 1ns/10ps
`include "thread_ops_map.vh"
module thread_ops_core (
    input  wire        clk_in,
    input  wire        rstn_in,
    input  wire        op_valid_in,
    input  wire [7:0]  opcode_in,
    input  wire [7:0]  operand_in,
    input  wire [15:0] pc_in,
    input  wire [7:0]  wreg_rdata_in,
    input  wire [15:0] stack_rdata_in,
    input  wire [15:0] pmem_rdata_in,
    input  wire        irq_pending_in,
    output reg         busy_out,
    output reg         done_out,
    output reg  [15:0] pc_out,
    output reg         pc_load_out,
    output reg  [15:0] instruction_ptr_out,
    output reg  [15:0] stack_ptr_out,
    output reg  [7:0]  system_mode_reg_out,
    output reg  [3:0]  wreg_addr_out,
    output reg  [7:0]  wreg_wdata_out,
    output reg         wreg_we_out,
    output reg  [15:0] stack_addr_out,
    output reg  [15:0] stack_wdata_out,
    output reg         stack_we_out,
    output reg  [15:0] pmem_addr_out,
    output reg         flags_we_out,
    output reg         irq_take_out
);
    localparam S_IDLE  = 3'd0;
    localparam S_LOOP  = 3'd1;
    localparam S_ENTER = 3'd2;
    localparam S_EXIT  = 3'd3;
    localparam S_FETCH = 3'd4;
    localparam S_WAIT  = 3'd5;
    localparam S_SRD   = 3'd6;
    localparam S_PRD   = 3'd7;

    localparam K_NONE  = 3'd0;
    localparam K_LOOP  = 3'd1;
    localparam K_IRQ   = 3'd2;
    localparam K_ENTER = 3'd3;
    localparam K_EXIT  = 3'd4;

    reg [2:0]  state_q;
    reg [15:0] next_pc_q;
    reg [4:0]  cycles_q;
    reg        start_q;
    wire       timer_done;
    wire [2:0] op_kind;

    ////////////////////////////////////////////////////////////////////////////
    function [15:0] rel_target;
        input [15:0] base;
        input [7:0]  disp;
        begin
            rel_target = base + {{8{disp[7]}}, disp};
        end
    endfunction

    function [2:0] op_class;
        input [7:0] opc;
        begin
            if (opc[3:0] == `OPC_LOOP_LOW)
                op_class = K_LOOP;
            else if (opc == `OPC_IRQ_ENABLE)
                op_class = K_IRQ;
            else if (opc == `OPC_THREAD_ENTER)
                op_class = K_ENTER;
            else if (opc == `OPC_THREAD_EXIT)
                op_class = K_EXIT;
            else
                op_class = K_NONE;
        end
    endfunction

    // length of each recognised instruction
    function [4:0] op_cycles;
        input [2:0] kind;
        begin
            if (kind == K_LOOP)
                op_cycles = `CYC_LOOP;
            else if (kind == K_IRQ)
                op_cycles = `CYC_IRQ_ENABLE;
            else if (kind == K_ENTER)
                op_cycles = `CYC_THREAD_ENTER;
            else
                op_cycles = `CYC_THREAD_EXIT;
        end
    endfunction

    assign op_kind = op_class(opcode_in);

    op_cycle_timer #(.W(5)) u_timer (
        .clk_in    (clk_in),
        .rstn_in   (rstn_in),
        .start_in  (start_q),
        .cycles_in (cycles_q),
        .done_out  (timer_done)
    );

    ////////////////////////////////////////////////////////////////////////////
    always @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            state_q             <= S_IDLE;
            next_pc_q           <= `RST_PC;
            cycles_q            <= 5'd0;
            start_q             <= 1'b0;
            busy_out            <= 1'b0;
            done_out            <= 1'b0;
            pc_out              <= `RST_PC;
            pc_load_out         <= 1'b0;
            instruction_ptr_out <= `RST_IP;
            stack_ptr_out       <= `RST_SP;
            system_mode_reg_out <= `RST_MODE;
            wreg_addr_out       <= 4'h0;
            wreg_wdata_out      <= 8'h00;
            wreg_we_out         <= 1'b0;
            stack_addr_out      <= 16'h0000;
            stack_wdata_out     <= 16'h0000;
            stack_we_out        <= 1'b0;
            pmem_addr_out       <= 16'h0000;
            flags_we_out        <= 1'b0;
            irq_take_out        <= 1'b0;
        end else begin
            start_q      <= 1'b0;
            done_out     <= 1'b0;
            pc_load_out  <= 1'b0;
            wreg_we_out  <= 1'b0;
            stack_we_out <= 1'b0;
            flags_we_out <= 1'b0;
            irq_take_out <= irq_pending_in &
                            system_mode_reg_out[`MODE_IRQ_EN_BIT] & !busy_out;
            case (state_q)
            S_IDLE: begin
                if (op_valid_in) begin
                    cycles_q <= op_cycles(op_kind);
                    start_q  <= 1'b1;
                    busy_out <= 1'b1;
                    if (op_kind == K_LOOP) begin
                        wreg_addr_out <= opcode_in[7:4];
                        next_pc_q     <= pc_in;
                        state_q       <= S_LOOP;
                    end else if (op_kind == K_IRQ) begin
                        system_mode_reg_out[`MODE_IRQ_EN_BIT] <= 1'b1;
                        state_q <= S_WAIT;
                    end else if (op_kind == K_ENTER) begin
                        stack_ptr_out   <= stack_ptr_out - `PTR_STEP;
                        stack_addr_out  <= stack_ptr_out - `PTR_STEP;
                        stack_wdata_out <= instruction_ptr_out;
                        stack_we_out    <= 1'b1;
                        next_pc_q       <= pc_in;
                        state_q         <= S_ENTER;
                    end else if (op_kind == K_EXIT) begin
                        stack_addr_out <= stack_ptr_out;
                        state_q        <= S_SRD;
                    end else begin
                        start_q  <= 1'b0;
                        busy_out <= 1'b0;
                    end
                end
            end
            S_LOOP: begin
                wreg_wdata_out <= wreg_rdata_in - 8'h01;
                wreg_we_out    <= 1'b1;
                if (wreg_rdata_in != 8'h01) begin
                    pc_out      <= rel_target(next_pc_q, operand_in);
                    pc_load_out <= 1'b1;
                end
                state_q <= S_WAIT;
            end
            S_ENTER: begin
                instruction_ptr_out <= next_pc_q;
                pmem_addr_out       <= next_pc_q;
                state_q             <= S_PRD;
            end
            S_SRD: begin
                // stack word answers one cycle after its address
                state_q <= S_EXIT;
            end
            S_PRD: begin
                // program word answers one cycle after its address
                state_q <= S_FETCH;
            end
            S_EXIT: begin
                instruction_ptr_out <= stack_rdata_in;
                pmem_addr_out       <= stack_rdata_in;
                stack_ptr_out       <= stack_ptr_out + `PTR_STEP;
                state_q             <= S_PRD;
            end
            S_FETCH: begin
                pc_out              <= pmem_rdata_in;
                pc_load_out         <= 1'b1;
                instruction_ptr_out <= instruction_ptr_out + `PTR_STEP;
                state_q             <= S_WAIT;
            end
            S_WAIT: begin
                if (timer_done) begin
                    done_out <= 1'b1;
                    busy_out <= 1'b0;
                    state_q  <= S_IDLE;
                end
            end
            default: state_q <= S_IDLE;
            endcase
        end
    end
endmodule

/* thread_ops_mem_model.sv */
// working register, stack and program memory model
`timescale 1ns/10ps
module thread_ops_mem_model (
    input  wire logic        clk_in, wreg_we_in, stack_we_in,
    input  wire logic [3:0]  wreg_addr_in,
    input  wire logic [7:0]  wreg_wdata_in,
    input  wire logic [15:0] stack_addr_in, stack_wdata_in, pmem_addr_in,
    output logic      [7:0]  wreg_rdata_out,
    output logic      [15:0] stack_rdata_out, pmem_rdata_out
);
    logic [7:0]  wr [16];
    logic [15:0] st [256];
    assign wreg_rdata_out = wr[wreg_addr_in];
    always @(posedge clk_in) begin
        if (wreg_we_in) wr[wreg_addr_in] <= wreg_wdata_in;
        if (stack_we_in) st[stack_addr_in[7:0]] <= stack_wdata_in;
        stack_rdata_out <= st[stack_addr_in[7:0]];
        // program word is a fixed pattern of its address
        pmem_rdata_out <= pmem_addr_in ^ 16'h5a5a;
    end
endmodule

/* thread_ops_core_asserts.sv */
// assertions on the loop, enable and threaded-code unit
`timescale 1ns/10ps
module thread_ops_core_asserts (
    input wire logic        clk_in, rstn_in, op_valid_in, busy_out, done_out, pc_load_out,
    input wire logic        wreg_we_out, stack_we_out, flags_we_out, irq_take_out,
    input wire logic [7:0]  opcode_in, operand_in, wreg_rdata_in, wreg_wdata_out,
    input wire logic [7:0]  system_mode_reg_out,
    input wire logic [15:0] pc_in, pc_out, stack_ptr_out, stack_addr_out, stack_wdata_out,
    input wire logic [15:0] instruction_ptr_out
);
    wire tk = op_valid_in && !busy_out;
    default clocking @(posedge clk_in); endclocking
    default disable iff (!rstn_in);
    flag_hold_a: assert property (!flags_we_out) else $error("flag write");
    loop_len_a: assert property (tk && opcode_in[3:0] == 4'ha |-> ##[9:10] done_out)
        else $error("loop length");
    en_len_a: assert property (tk && opcode_in == 8'h9f |-> ##[5:6] done_out)
        else $error("enable length");
    mode_set_a: assert property (tk && opcode_in == 8'h9f |-> ##[1:3] system_mode_reg_out[0])
        else $error("mode bit");
    enter_len_a: assert property (tk && opcode_in == 8'h1f |-> ##[15:16] done_out)
        else $error("enter length");
    exit_len_a: assert property (tk && opcode_in == 8'h2f |-> ##[17:18] done_out)
        else $error("exit length");
    push_a: assert property (stack_we_out |-> stack_addr_out == stack_ptr_out
        && stack_wdata_out == instruction_ptr_out) else $error("push");
    dec_a: assert property (wreg_we_out |-> wreg_wdata_out == $past(wreg_rdata_in) - 8'h01)
        else $error("decrement");
    branch_a: assert property (wreg_we_out |-> pc_load_out == (wreg_wdata_out != 8'h00))
        else $error("branch");
    disp_a: assert property (wreg_we_out && pc_load_out
        |-> pc_out == $past(pc_in, 2) + {{8{operand_in[7]}}, operand_in})
        else $error("target");
    irq_a: assert property (irq_take_out |-> system_mode_reg_out[0]) else $error("irq");
    cover property (wreg_we_out && !pc_load_out);
    cover property (wreg_we_out && wreg_wdata_out == 8'hff);
    cover property (stack_we_out);
endmodule

/* loop_irq_enable_threaded_ops_bench.sv */
// testbench for the loop, enable and threaded-code unit
`timescale 1ns/10ps
module loop_irq_enable_threaded_ops_bench;
    logic clk_in = 0, rstn_in = 0, op_valid_in = 0, irq_pending_in = 0, ld_q = 0;
    logic [7:0] opcode_in = 8'h00, operand_in = 8'h00;
    logic [15:0] pc_in = 16'h0000, pc_q, n;
    wire busy_out, done_out, pc_load_out, wreg_we_out, stack_we_out, flags_we_out, irq_take_out;
    wire [3:0] wreg_addr_out;
    wire [7:0] wreg_rdata_in, system_mode_reg_out, wreg_wdata_out;
    wire [15:0] stack_rdata_in, pmem_rdata_in, pc_out, instruction_ptr_out, stack_ptr_out;
    wire [15:0] stack_addr_out, stack_wdata_out, pmem_addr_out;
    integer mismatches = 0, comparisons = 0;
    thread_ops_core dut (.clk_in, .rstn_in, .op_valid_in, .opcode_in, .operand_in, .pc_in,
        .wreg_rdata_in, .stack_rdata_in, .pmem_rdata_in, .irq_pending_in, .busy_out, .done_out,
        .pc_out, .pc_load_out, .instruction_ptr_out, .stack_ptr_out, .system_mode_reg_out,
        .wreg_addr_out, .wreg_wdata_out, .wreg_we_out, .stack_addr_out, .stack_wdata_out,
        .stack_we_out, .pmem_addr_out, .flags_we_out, .irq_take_out);
    thread_ops_mem_model pm (.clk_in, .wreg_we_in(wreg_we_out), .stack_we_in(stack_we_out),
        .wreg_addr_in(wreg_addr_out), .wreg_wdata_in(wreg_wdata_out),
        .stack_addr_in(stack_addr_out), .stack_wdata_in(stack_wdata_out),
        .pmem_addr_in(pmem_addr_out), .wreg_rdata_out(wreg_rdata_in),
        .stack_rdata_out(stack_rdata_in), .pmem_rdata_out(pmem_rdata_in));
    initial forever #4 clk_in = ~clk_in;
    always @(posedge clk_in) if (pc_load_out) begin pc_q <= pc_out; ld_q <= 1'b1; end
    task chk(input [15:0] g, input [15:0] e);
        comparisons++;
        if (g !== e) begin
            mismatches++;
            $display("ERROR t=%0t got %h exp %h", $time, g, e);
        end
    endtask
    task results;
        $display("mismatches=%0d comparisons=%0d", mismatches, comparisons);
        if (mismatches == 0 && comparisons > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // one instruction; counts busy cycles
    task op(input [7:0] o, input [7:0] d, input [15:0] p);
        @(negedge clk_in); op_valid_in = 1; opcode_in = o; operand_in = d; pc_in = p; ld_q = 0;
        @(negedge clk_in); op_valid_in = 0; n = 0;
        repeat (20) begin @(negedge clk_in); if (busy_out === 1'b1) n = n + 1; end
    endtask
    // working set assumed in the 0c0 area
    task t_loop(input [3:0] r, input [7:0] v, input [7:0] d, input [15:0] p, input b);
        logic [7:0] e;
        e = v - 8'h01;
        pm.wr[r] = v;
        op({r, 4'ha}, d, p);
        chk(n, 16'd8);
        chk(pm.wr[r], e);
        chk(ld_q, b);
        if (b) chk(pc_q, p + {{8{d[7]}}, d});
    endtask
    task t_en;
        irq_pending_in = 1;
        @(negedge clk_in); chk(irq_take_out, 0);
        op(8'h9f, 8'h00, 16'h0000);
        chk(n, 16'd4);
        chk(system_mode_reg_out, 8'h01);
        chk(irq_take_out, 1);
    endtask
    task t_thread;
        op(8'h1f, 8'h00, 16'h0200);
        chk(n, 16'd14);
        chk(stack_ptr_out, 16'hfffe);
        chk(pm.st[8'hfe], 16'h0000);
        chk(instruction_ptr_out, 16'h0202);
        chk(pc_q, 16'h0200 ^ 16'h5a5a);
        pm.st[8'hfe] = 16'h0300;
        op(8'h2f, 8'h00, 16'h0201);
        chk(n, 16'd16);
        chk(stack_ptr_out, 16'h0000);
        chk(instruction_ptr_out, 16'h0302);
        chk(pc_q, 16'h0300 ^ 16'h5a5a);
    endtask
    initial begin
        repeat (2) @(negedge clk_in);
        rstn_in = 1;
        t_loop(4'h1, 8'h02, 8'h80, 16'h1000, 1);
        t_loop(4'h2, 8'h01, 8'h10, 16'h1000, 0);
        t_loop(4'hf, 8'h00, 8'h7f, 16'h2000, 1);
        t_en;
        t_thread;
        results;
    end
    initial begin #20000; mismatches++; results; end
endmodule
bind thread_ops_core thread_ops_core_asserts chk_i (.clk_in, .rstn_in, .op_valid_in, .busy_out,
    .done_out, .pc_load_out, .wreg_we_out, .stack_we_out, .flags_we_out, .irq_take_out,
    .opcode_in, .operand_in, .wreg_rdata_in, .wreg_wdata_out, .system_mode_reg_out, .pc_in,
    .pc_out, .stack_ptr_out, .stack_addr_out, .stack_wdata_out, .instruction_ptr_out);
